// File: spio_pkg.sv
/*
  Package for the shared parallel I/O ports: register offsets, reset
  values, pin masks and the pin drive carrier.
  Assumes an 8-bit register port with a 16-bit byte address.
*/
package spio_pkg;

  // Register byte addresses
  localparam logic [15:0] SPIO_OFS_LAT_A = 16'h0000; // First port data latch
  localparam logic [15:0] SPIO_OFS_LAT_B = 16'h0001; // Second port data latch
  localparam logic [15:0] SPIO_OFS_LAT_C = 16'h0002; // Third port data latch
  localparam logic [15:0] SPIO_OFS_DIR_A = 16'h0004; // First port direction
  localparam logic [15:0] SPIO_OFS_DIR_B = 16'h0005; // Second port direction
  localparam logic [15:0] SPIO_OFS_DIR_C = 16'h0006; // Third port direction
  localparam logic [15:0] SPIO_OFS_LED_A = 16'h000C; // First port high sink enable

  // Values after reset
  localparam logic [7:0] SPIO_DIR_RST = 8'h00; // All pins inputs
  localparam logic [7:0] SPIO_LED_RST = 8'h00; // Standard drive
  localparam logic [7:0] SPIO_OUT_RST = 8'h00; // Output flops after reset
  localparam logic [7:0] SPIO_UNMAPPED = 8'h00; // Read value of a hole

  // Pins that only pull low when driven
  localparam logic [7:0] SPIO_OD_B = 8'h0F;
  localparam logic [7:0] SPIO_OD_NONE = 8'h00;

  // Converter channels that land on first port pins
  localparam logic [4:0] SPIO_ADC_PINS = 5'h08;
  // Timer edge/level code that leaves the pin to the port
  localparam logic [1:0] SPIO_ELS_GPIO = 2'h0;
  // Number of timer channels sharing the second port
  localparam int SPIO_TIM_CH = 4;

  // Drive of one 8-bit pin group: value and output enable
  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] oe;
  } spio_drv_t;

endpackage

// File: spio_port_slice.sv
/*
  One 8-bit port: chooses between port logic and a peripheral per pin,
  applies open-drain behaviour, and forms the value a data read returns.
  Purely combinational; the parent registers everything it passes on.
*/
`timescale 1ns/100ps
module spio_port_slice import spio_pkg::*; #(
  parameter logic [7:0] OD_MASK = 8'h00
) (
  // Port state
  input wire logic [7:0] latch,
  input wire logic [7:0] dir,
  // Pins handed to a peripheral, and that peripheral's drive
  input wire logic [7:0] own,
  input wire spio_drv_t periph,
  // Pins parked with no digital drive (analogue use)
  input wire logic [7:0] park,
  // Pin level
  input wire logic [7:0] pin_in,
  // Resulting pin drive and read value
  output spio_drv_t pin,
  output logic [7:0] rd_val
);

  // Raw drive before open-drain shaping
  wire [7:0] raw_dout;
  wire [7:0] raw_oe;

  // Peripheral wins over port control where it owns the pin
  assign raw_dout = (own & periph.dout) | (~own & latch);
  assign raw_oe = ((own & periph.oe) | (~own & dir)) & ~park;

  // Open-drain pins drive only low, and only while the value is zero
  assign pin.dout = raw_dout & ~OD_MASK;
  assign pin.oe = raw_oe & ~(OD_MASK & raw_dout);

  // Output pins read the latch, input pins read the level
  assign rd_val = (dir & latch) | (~dir & pin_in);

endmodule // spio_port_slice

// File: spio_ports.sv
/*
  Three 8-bit general-purpose ports with latches, direction bits, high
  sink drive on the first port and peripheral overrides.
  Assumes one clock, pins sampled synchronously, and a register port
  whose read data stand in the cycle after the read strobe.
*/
// The implementer's own choice: strobed register access.
`timescale 1ns/100ps
module spio_ports import spio_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Register port
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr_stb,
  input wire logic reg_rd_stb,
  output logic [7:0] reg_rdata_q,
  // Pin levels
  input wire logic [7:0] pin_a_in,
  input wire logic [7:0] pin_b_in,
  input wire logic [7:0] pin_c_in,
  // Pin drive
  output spio_drv_t pin_a_q,
  output spio_drv_t pin_b_q,
  output spio_drv_t pin_c_q,
  output logic [7:0] high_sink_enable_q,
  output logic pin_c0_pullup_q,
  // Peripheral controls
  input wire logic iic_module_enable,
  input wire logic serial_module_enable,
  input wire logic spi_enable_bit,
  input wire logic infrared_serial_enable,
  input wire logic [7:0] timer_edge_level_select,
  input wire logic [4:0] converter_channel_select,
  input wire logic pin0_pullup_disable,
  // Peripheral drive of shared pins
  input wire spio_drv_t periph_b_drv,
  input wire spio_drv_t periph_c_drv,
  // Pin levels and the analogue pin selection handed to peripherals
  output logic [7:0] level_b_q,
  output logic [7:0] level_c_q,
  output logic second_external_interrupt_q,
  output logic [7:0] analog_sel_q
);

  // Data latches, no reset
  logic [7:0] latch_first_port;
  logic [7:0] latch_second_port;
  logic [7:0] latch_third_port;
  // Direction and high sink registers
  logic [7:0] dir_bits_first_port;
  logic [7:0] dir_bits_second_port;
  logic [7:0] dir_bits_third_port;
  logic [7:0] high_sink_enable;

  // Address decode
  wire hit_lat_a = (reg_addr == SPIO_OFS_LAT_A);
  wire hit_lat_b = (reg_addr == SPIO_OFS_LAT_B);
  wire hit_lat_c = (reg_addr == SPIO_OFS_LAT_C);
  wire hit_dir_a = (reg_addr == SPIO_OFS_DIR_A);
  wire hit_dir_b = (reg_addr == SPIO_OFS_DIR_B);
  wire hit_dir_c = (reg_addr == SPIO_OFS_DIR_C);
  wire hit_led_a = (reg_addr == SPIO_OFS_LED_A);

  // Write enables per register
  wire wr_lat_a = reg_wr_stb & hit_lat_a;
  wire wr_lat_b = reg_wr_stb & hit_lat_b;
  wire wr_lat_c = reg_wr_stb & hit_lat_c;
  wire wr_dir_a = reg_wr_stb & hit_dir_a;
  wire wr_dir_b = reg_wr_stb & hit_dir_b;
  wire wr_dir_c = reg_wr_stb & hit_dir_c;
  wire wr_led_a = reg_wr_stb & hit_led_a;

  // Pin ownership by peripherals
  logic [7:0] own_b;
  logic [7:0] own_c;
  logic [7:0] park_a;
  wire [SPIO_TIM_CH-1:0] tim_own;

  // Each timer channel claims its pin unless its code says port use
  genvar gch;
  generate
    for (gch = 0; gch < SPIO_TIM_CH; gch = gch + 1) begin : g_tim
      assign tim_own[gch] = (timer_edge_level_select[2*gch +: 2] != SPIO_ELS_GPIO);
    end
  endgenerate

  // Second port: IIC on 0-1, serial on 2-3, timers on 4-7
  assign own_b = {tim_own, {2{serial_module_enable}}, {2{iic_module_enable}}};
  // Third port: SPI on 2-5, infrared serial on 6-7, pins 0-1 stay port
  assign own_c = {{2{infrared_serial_enable}}, {4{spi_enable_bit}}, 2'h0};

  // Converter channel below the pin count parks that first port pin
  assign park_a = (converter_channel_select < SPIO_ADC_PINS)
                  ? (8'h01 << converter_channel_select[2:0]) : 8'h00;

  // Slice outputs
  spio_drv_t drv_a;
  spio_drv_t drv_b;
  spio_drv_t drv_c;
  logic [7:0] rd_a;
  logic [7:0] rd_b;
  logic [7:0] rd_c;

  // First port: no digital peripheral, analogue parking only
  spio_port_slice #(.OD_MASK(SPIO_OD_NONE)) u_port_a (
    .latch(latch_first_port),
    .dir(dir_bits_first_port),
    .own(8'h00),
    .periph('0),
    .park(park_a),
    .pin_in(pin_a_in),
    .pin(drv_a),
    .rd_val(rd_a)
  );

  // Second port: low nibble open-drain
  spio_port_slice #(.OD_MASK(SPIO_OD_B)) u_port_b (
    .latch(latch_second_port),
    .dir(dir_bits_second_port),
    .own(own_b),
    .periph(periph_b_drv),
    .park(8'h00),
    .pin_in(pin_b_in),
    .pin(drv_b),
    .rd_val(rd_b)
  );

  // Third port: SPI and infrared serial overrides
  spio_port_slice #(.OD_MASK(SPIO_OD_NONE)) u_port_c (
    .latch(latch_third_port),
    .dir(dir_bits_third_port),
    .own(own_c),
    .periph(periph_c_drv),
    .park(8'h00),
    .pin_in(pin_c_in),
    .pin(drv_c),
    .rd_val(rd_c)
  );

  // Read selection; holes read as zero
  wire [7:0] rdata_d =
    hit_lat_a ? rd_a :
    hit_lat_b ? rd_b :
    hit_lat_c ? rd_c :
    hit_dir_a ? dir_bits_first_port :
    hit_dir_b ? dir_bits_second_port :
    hit_dir_c ? dir_bits_third_port :
    hit_led_a ? high_sink_enable : SPIO_UNMAPPED;

  // High sink only where the pin actually drives
  wire [7:0] sink_d = high_sink_enable & drv_a.oe;

  // Data latches: written whatever the direction, untouched by reset
  always_ff @(posedge ref_clk) begin
    if (wr_lat_a) begin
      latch_first_port <= reg_wdata;
    end
    if (wr_lat_b) begin
      latch_second_port <= reg_wdata;
    end
    if (wr_lat_c) begin
      latch_third_port <= reg_wdata;
    end
  end

  // Direction and high sink registers
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      dir_bits_first_port <= SPIO_DIR_RST;
      dir_bits_second_port <= SPIO_DIR_RST;
      dir_bits_third_port <= SPIO_DIR_RST;
      high_sink_enable <= SPIO_LED_RST;
    end else begin
      if (wr_dir_a) begin
        dir_bits_first_port <= reg_wdata;
      end
      if (wr_dir_b) begin
        dir_bits_second_port <= reg_wdata;
      end
      if (wr_dir_c) begin
        dir_bits_third_port <= reg_wdata;
      end
      if (wr_led_a) begin
        high_sink_enable <= reg_wdata;
      end
    end
  end

  // Read data, valid the cycle after the strobe only
  always_ff @(posedge ref_clk) begin
    if (!rst_b || !reg_rd_stb) begin
      reg_rdata_q <= SPIO_OUT_RST;
    end else begin
      reg_rdata_q <= rdata_d;
    end
  end

  // Registered pin drive and peripheral-facing levels
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pin_a_q <= '0;
      pin_b_q <= '0;
      pin_c_q <= '0;
      high_sink_enable_q <= SPIO_OUT_RST;
      pin_c0_pullup_q <= 1'b0;
      level_b_q <= SPIO_OUT_RST;
      level_c_q <= SPIO_OUT_RST;
      second_external_interrupt_q <= 1'b1;
      analog_sel_q <= SPIO_OUT_RST;
    end else begin
      pin_a_q <= drv_a;
      pin_b_q <= drv_b;
      pin_c_q <= drv_c;
      high_sink_enable_q <= sink_d;
      pin_c0_pullup_q <= ~pin0_pullup_disable;
      level_b_q <= pin_b_in;
      level_c_q <= pin_c_in;
      second_external_interrupt_q <= pin_c_in[0];
      analog_sel_q <= park_a;
    end
  end

  // Reset leaves every pin an input
  AST_DIR_RESET: assert property (@(posedge ref_clk)
    !rst_b |=> (dir_bits_first_port == 8'h00) && (dir_bits_second_port == 8'h00)
               && (dir_bits_third_port == 8'h00))
    else $error("direction not cleared by reset");

  // All-output port reads back its latch
  AST_READ_LATCH: assert property (@(posedge ref_clk) disable iff (!rst_b)
    reg_rd_stb && hit_lat_b && (dir_bits_second_port == 8'hFF)
      |=> reg_rdata_q == $past(latch_second_port))
    else $error("output port read did not return latch");

  // All-input port reads back its pin levels
  AST_READ_PIN: assert property (@(posedge ref_clk) disable iff (!rst_b)
    reg_rd_stb && hit_lat_c && (dir_bits_third_port == 8'h00)
      |=> reg_rdata_q == $past(pin_c_in))
    else $error("input port read did not return pin level");

  // Latch write lands even on inputs, next edge
  AST_LATCH_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_b)
    wr_lat_a |=> latch_first_port == $past(reg_wdata))
    else $error("latch write lost");

  // Reset does not disturb the latches
  AST_LATCH_KEEP: assert property (@(posedge ref_clk)
    !rst_b && !reg_wr_stb |=> latch_third_port === $past(latch_third_port))
    else $error("latch changed by reset");

  // High sink follows a write two edges later on driven pins
  AST_SINK: assert property (@(posedge ref_clk) disable iff (!rst_b)
    wr_led_a ##1 (!reg_wr_stb && park_a == 8'h00)
      |=> high_sink_enable_q == ($past(reg_wdata, 2) & $past(dir_bits_first_port)))
    else $error("high sink drive mismatch");

  // Open-drain pins never drive high
  AST_OPEN_DRAIN: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (pin_b_q.dout[3:0] == 4'h0)
      and (($past(latch_second_port[0]) && !$past(iic_module_enable)) |-> !pin_b_q.oe[0]))
    else $error("open-drain pin driven high");

  // IIC enable hands pins 0-1 to the IIC drive
  AST_IIC_OWN: assert property (@(posedge ref_clk) disable iff (!rst_b)
    iic_module_enable && !periph_b_drv.dout[0] |=> pin_b_q.oe[0] == $past(periph_b_drv.oe[0]))
    else $error("IIC did not take its pin");

  // Serial enable hands pins 2-3 to the serial drive
  AST_SCI_OWN: assert property (@(posedge ref_clk) disable iff (!rst_b)
    serial_module_enable && !periph_b_drv.dout[2]
      |=> pin_b_q.oe[2] == $past(periph_b_drv.oe[2]))
    else $error("serial did not take its pin");

  // Timer code zero leaves the pin to the port
  AST_TIM_GPIO: assert property (@(posedge ref_clk) disable iff (!rst_b)
    timer_edge_level_select[1:0] == 2'h0 |=> pin_b_q.oe[4] == $past(dir_bits_second_port[4]))
    else $error("timer took a port pin");

  // Interrupt input sees pin 0 whatever the port does
  AST_IRQ_FEED: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $rose(pin_c_in[0]) |=> second_external_interrupt_q)
    else $error("interrupt input missed pin level");

  // Pull-up follows the disable bit
  AST_PULLUP: assert property (@(posedge ref_clk) disable iff (!rst_b)
    pin0_pullup_disable [*2] |-> !pin_c0_pullup_q)
    else $error("pull-up on while disabled");

  // SPI enable hands pins 2-5 to SPI drive
  AST_SPI_OWN: assert property (@(posedge ref_clk) disable iff (!rst_b)
    spi_enable_bit |=> pin_c_q.oe[5:2] == $past(periph_c_drv.oe[5:2]))
    else $error("SPI did not take its pins");

  // Infrared serial hands pins 6-7 to its drive
  AST_IRSCI_OWN: assert property (@(posedge ref_clk) disable iff (!rst_b)
    infrared_serial_enable |=> pin_c_q.dout[7:6] == $past(periph_c_drv.dout[7:6]))
    else $error("infrared serial did not take its pins");

  // Selected analogue pin is never driven
  AST_ADC_PARK: assert property (@(posedge ref_clk) disable iff (!rst_b)
    converter_channel_select == 5'h03 |=> !pin_a_q.oe[3] && analog_sel_q[3])
    else $error("analogue pin still driven");

  // Direction write lands on the next edge
  AST_DIR_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_b)
    wr_dir_c |=> dir_bits_third_port == $past(reg_wdata))
    else $error("direction write lost");

endmodule // spio_ports

// File: spio_pin_model.sv
/*
  Far side of the three ports: resolves each pin level from the block's
  drive, an external source set by the bench, pull-ups and floating lines.
  Assumes the bench never drives a pin that the block drives.
*/
`timescale 1ns/100ps
module spio_pin_model import spio_pkg::*; (
  // Clock
  input wire logic ref_clk,
  // Block drive
  input wire spio_drv_t pin_a_q,
  input wire spio_drv_t pin_b_q,
  input wire spio_drv_t pin_c_q,
  input wire logic pin_c0_pullup_q,
  // External sources, bits 7:0 first port, 15:8 second, 23:16 third
  input wire logic [23:0] ext_en,
  input wire logic [23:0] ext_val,
  // Resolved levels
  output logic [7:0] pin_a_in,
  output logic [7:0] pin_b_in,
  output logic [7:0] pin_c_in
);
  // Floating lines toggle so no stale value survives
  logic flt_q = 1'b0;
  wire logic [23:0] drv_oe = {pin_c_q.oe, pin_b_q.oe, pin_a_q.oe};
  wire logic [23:0] drv_val = {pin_c_q.dout, pin_b_q.dout, pin_a_q.dout};
  // Board pull-ups on open-drain lines, internal one on third port pin 0
  wire logic [23:0] pull_en = {7'h00, pin_c0_pullup_q, 4'h0, 4'hF, 8'h00};
  wire logic [23:0] idle = ~ext_en & (pull_en | {24{flt_q}});
  wire logic [23:0] lvl = (drv_oe & drv_val) | (~drv_oe & ((ext_en & ext_val) | idle));

  // Float pattern
  always_ff @(posedge ref_clk) begin
    flt_q <= ~flt_q;
  end

  assign pin_a_in = lvl[7:0];
  assign pin_b_in = lvl[15:8];
  assign pin_c_in = lvl[23:16];
endmodule // spio_pin_model

// File: tb_spio_ports.sv
/*
  Self-checking bench for the three ports: register accesses, pin drive,
  overrides and reset behaviour.
  Assumes the pin model above and registered outputs one edge late.
*/
`timescale 1ns/100ps
`define CHK(a, e) begin \
  total_checks++; \
  if ((a) !== (e)) begin \
    errors++; \
    $display("ERROR %0t got %h exp %h", $time, (a), (e)); \
  end \
end
module tb_spio_ports;
  import spio_pkg::*;
  // Stimulus
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr_stb = 1'b0;
  logic reg_rd_stb = 1'b0;
  logic iic = 1'b0, sci = 1'b0, spi = 1'b0, irs = 1'b0, pud = 1'b0;
  logic [7:0] tels = 8'h00;
  logic [4:0] ccs = 5'h1F;
  spio_drv_t pb = '{dout: 8'h9A, oe: 8'hFF};
  spio_drv_t pc = '{dout: 8'hF0, oe: 8'h55};
  logic [23:0] ext_en = 24'hFF00FF;
  logic [23:0] ext_val = 24'h69003C;
  // Observed
  logic [7:0] reg_rdata_q, pa_in, pb_in, pc_in, hs_q, lvl_b, lvl_c, asel;
  spio_drv_t pin_a_q, pin_b_q, pin_c_q;
  logic pu_q, irq_q;
  int errors = 0;
  int total_checks = 0;
  logic [7:0] own_b [4] = '{8'h03, 8'h0C, 8'h10, 8'hC0};

  spio_ports spio_ports_i (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb),
    .reg_rdata_q(reg_rdata_q), .pin_a_in(pa_in), .pin_b_in(pb_in), .pin_c_in(pc_in),
    .pin_a_q(pin_a_q), .pin_b_q(pin_b_q), .pin_c_q(pin_c_q), .high_sink_enable_q(hs_q),
    .pin_c0_pullup_q(pu_q), .iic_module_enable(iic), .serial_module_enable(sci),
    .spi_enable_bit(spi), .infrared_serial_enable(irs), .timer_edge_level_select(tels),
    .converter_channel_select(ccs), .pin0_pullup_disable(pud), .periph_b_drv(pb),
    .periph_c_drv(pc), .level_b_q(lvl_b), .level_c_q(lvl_c),
    .second_external_interrupt_q(irq_q), .analog_sel_q(asel));

  spio_pin_model spio_pin_model_i (.ref_clk(ref_clk), .pin_a_q(pin_a_q), .pin_b_q(pin_b_q),
    .pin_c_q(pin_c_q), .pin_c0_pullup_q(pu_q), .ext_en(ext_en), .ext_val(ext_val),
    .pin_a_in(pa_in), .pin_b_in(pb_in), .pin_c_in(pc_in));

  // 200 MHz clock
  always #2.5 ref_clk = ~ref_clk;

  // Expected drive: peripheral or port per pin, then open-drain mask
  function automatic spio_drv_t exp_drv(logic [7:0] own, logic [7:0] lat, logic [7:0] dir,
                                        spio_drv_t p, logic [7:0] odm);
    logic [7:0] d;
    logic [7:0] o;
    spio_drv_t r;
    d = (own & p.dout) | (~own & lat);
    o = (own & p.oe) | (~own & dir);
    r.dout = d & ~odm;
    r.oe = o & ~(d & odm);
    return r;
  endfunction

  // Let n edges pass, then step off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // One-cycle write
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr_stb <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr_stb <= 1'b0;
  endtask

  // One-cycle read, data compared in the following cycle
  task automatic rdc(input logic [15:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_rd_stb <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd_stb <= 1'b0;
    #1;
    `CHK(reg_rdata_q, e)
  endtask

  // Hold reset low for 20 cycles
  task automatic do_reset();
    @(posedge ref_clk);
    rst_b <= 1'b0;
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
  endtask

  // Verdict and end of run
  task automatic finish_test();
    if (errors == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    #50000;
    errors++;
    finish_test();
  end

  // Main sequence
  initial begin
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    rdc(SPIO_OFS_DIR_A, SPIO_DIR_RST);
    rdc(SPIO_OFS_DIR_B, SPIO_DIR_RST);
    rdc(SPIO_OFS_DIR_C, SPIO_DIR_RST);
    rdc(SPIO_OFS_LED_A, SPIO_LED_RST);
    rdc(16'h0003, SPIO_UNMAPPED);
    rdc(SPIO_OFS_LAT_C, 8'h69);
    wr(SPIO_OFS_LAT_A, 8'hA5);
    rdc(SPIO_OFS_LAT_A, 8'h3C);
    tick(1);
    `CHK(reg_rdata_q, 8'h00)
    @(posedge ref_clk);
    ext_en <= 24'h0000F0;
    wr(SPIO_OFS_DIR_A, 8'h0F);
    rdc(SPIO_OFS_LAT_A, 8'h35);
    `CHK(pin_a_q.oe, 8'h0F)
    `CHK(pin_a_q.dout & 8'h0F, 8'h05)
    wr(SPIO_OFS_LED_A, 8'hFF);
    rdc(SPIO_OFS_LED_A, 8'hFF);
    `CHK(hs_q, 8'h0F)
    @(posedge ref_clk);
    ext_en <= 24'h000000;
    wr(SPIO_OFS_DIR_A, 8'hFF);
    ccs <= 5'd3;
    tick(2);
    `CHK(pin_a_q.oe, 8'hF7)
    `CHK(asel, 8'h08)
    @(posedge ref_clk);
    ccs <= 5'd8;
    tick(2);
    `CHK(pin_a_q.oe, 8'hFF)
    `CHK(asel, 8'h00)
    do_reset();
    rdc(SPIO_OFS_DIR_A, SPIO_DIR_RST);
    wr(SPIO_OFS_DIR_A, 8'hFF);
    rdc(SPIO_OFS_LAT_A, 8'hA5);
    wr(SPIO_OFS_LAT_B, 8'h5A);
    wr(SPIO_OFS_DIR_B, 8'hFF);
    rdc(SPIO_OFS_LAT_B, 8'h5A);
    `CHK(pin_b_q, exp_drv(8'h00, 8'h5A, 8'hFF, pb, SPIO_OD_B))
    `CHK(lvl_b, 8'h5A)
    for (int k = 0; k < 4; k++) begin
      @(posedge ref_clk);
      iic <= (k == 0);
      sci <= (k == 1);
      tels <= (k == 2) ? 8'h01 : ((k == 3) ? 8'hB0 : 8'h00);
      tick(2);
      `CHK(pin_b_q, exp_drv(own_b[k], 8'h5A, 8'hFF, pb, SPIO_OD_B))
    end
    wr(SPIO_OFS_LAT_C, 8'h96);
    wr(SPIO_OFS_DIR_C, 8'hFF);
    for (int k = 0; k < 2; k++) begin
      @(posedge ref_clk);
      spi <= (k == 0);
      irs <= (k == 1);
      tick(2);
      `CHK(pin_c_q, exp_drv(k == 0 ? 8'h3C : 8'hC0, 8'h96, 8'hFF, pc, SPIO_OD_NONE))
    end
    `CHK(irq_q, 1'b0)
    @(posedge ref_clk);
    ext_en <= 24'h010000;
    ext_val <= 24'h010000;
    wr(SPIO_OFS_DIR_C, 8'hFE);
    rdc(SPIO_OFS_LAT_C, 8'h97);
    `CHK(irq_q, 1'b1)
    `CHK(lvl_c & 8'h7F, 8'h57)
    @(posedge ref_clk);
    pud <= 1'b1;
    tick(2);
    `CHK(pu_q, 1'b0)
    @(posedge ref_clk);
    pud <= 1'b0;
    tick(2);
    `CHK(pu_q, 1'b1)
    finish_test();
  end
endmodule // tb_spio_ports
